/* File: rtl/eoc_ctl_if.sv */
/*
 * link between the register block and the crystal qualifier.
 * assumes both ends run on the same core clock.
 */
interface eoc_ctl_if;
    logic xtal_en;
    logic stable;

    modport ctl (output xtal_en, input stable);
    modport det (input xtal_en, output stable);
endinterface

/* File: rtl/eoc_defines.svh */
/*
 * constants of the external oscillator control block: register address,
 * field positions, reset value, mode codes and timing figures.
 * assumes it is included by its bare name from the control block, the qualifier and the bench.
 */
`ifndef EOC_DEFINES_SVH
`define EOC_DEFINES_SVH

// register placement and reset value
`define EOC_REG_ADDR 8'hb1
`define EOC_REG_RESET 8'h00
`define EOC_RD_ZERO 8'h00

// field positions inside the control register
`define EOC_FLAG_BIT 7
`define EOC_MODE_MSB 6
`define EOC_MODE_LSB 4
`define EOC_RSVD_BIT 3
`define EOC_DRIVE_MSB 2
`define EOC_DRIVE_LSB 0

// mode field codes
`define EOC_MODE_OFF 3'h0
`define EOC_MODE_EXT_CLK 3'h2
`define EOC_MODE_EXT_CLK_DIV2 3'h3
`define EOC_MODE_RC 3'h4
`define EOC_MODE_CAP 3'h5
`define EOC_MODE_XTAL 3'h6
`define EOC_MODE_XTAL_DIV2 3'h7
`define EOC_OFF_PREFIX 2'h0
`define EOC_XTAL_PREFIX 2'h3

// drive code reset value
`define EOC_DRIVE_RESET 3'h0

// timing: core clock rate and amplitude detector settling time
`define EOC_CLK_MHZ 25
`define EOC_SETTLE_US 1000
`define EOC_CNT_W 16
`define EOC_CNT_ONE 16'h0001
`define EOC_CNT_ZERO 16'h0000

`endif

/* File: rtl/eoc_ext_osc_ctrl.sv */
/*
 * external oscillator control register and drive circuit decode.
 * holds mode and drive fields, forwards them to the analog drive
 * circuit and reports a qualified crystal stable flag.
 * assumes a single-cycle special function register port on the core
 * clock and an amplitude detector level synchronous to that clock.
 */
// Behaviour
// - mode field bits 6:4 chooses off, external clock, RC, capacitor or crystal.
// - bit 7 is a read-only flag, 1 only while crystal runs stably.
// - bit 3 always reads zero; writes to it are ignored.
// - drive code bits 2:0 is stored and forwarded to oscillator bias.
// - flag stays low after crystal enable until amplitude detector has settled.
`include "eoc_defines.svh"

module eoc_ext_osc_ctrl #(
    parameter logic [`EOC_CNT_W-1:0] SETTLE_CYCLES =
        `EOC_CNT_W'(`EOC_SETTLE_US * `EOC_CLK_MHZ)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // amplitude detector
    input wire logic amp_ok_i,
    // analog drive circuit controls
    output eoc_pkg::eoc_src_t osc_src_o,
    output logic osc_div2_o,
    output logic [2:0] ext_osc_drive_select_o,
    output logic amp_det_en_o,
    output logic osc_pin_input_used_o,
    output logic osc_pin_output_used_o
);
    import eoc_pkg::*;

    eoc_ctl_if ctl_link ();

    // register fields
    logic [2:0] ext_osc_mode_select;
    logic [2:0] ext_osc_drive_select;

    // address decode
    logic reg_sel;
    logic wr_hit;
    logic rd_hit;
    assign reg_sel = (sfr_addr_i == `EOC_REG_ADDR);
    assign wr_hit = sfr_wr_i && reg_sel;
    assign rd_hit = sfr_rd_i && reg_sel;

    // next field values; bits 7 and 3 of a write are dropped
    logic [2:0] next_mode;
    logic [2:0] next_drive;
    assign next_mode = wr_hit ?
        sfr_wdata_i[`EOC_MODE_MSB:`EOC_MODE_LSB] : ext_osc_mode_select;
    assign next_drive = wr_hit ?
        sfr_wdata_i[`EOC_DRIVE_MSB:`EOC_DRIVE_LSB] : ext_osc_drive_select;

    // mode decode from the next value so decoded outputs stay flops
    eoc_src_t next_src;
    logic next_div2;
    logic next_xtal;
    logic next_off;
    assign next_off = (next_mode[2:1] == `EOC_OFF_PREFIX);
    assign next_xtal = (next_mode[2:1] == `EOC_XTAL_PREFIX);
    assign next_src =
        next_off ? EOC_SRC_NONE :
        (next_mode == `EOC_MODE_EXT_CLK) ? EOC_SRC_CLOCK :
        (next_mode == `EOC_MODE_EXT_CLK_DIV2) ? EOC_SRC_CLOCK :
        (next_mode == `EOC_MODE_RC) ? EOC_SRC_RC :
        (next_mode == `EOC_MODE_CAP) ? EOC_SRC_CAP :
        EOC_SRC_XTAL;
    assign next_div2 = (next_mode == `EOC_MODE_EXT_CLK_DIV2) ||
        (next_mode == `EOC_MODE_XTAL_DIV2);

    // qualified flag: masked the moment crystal mode is left, so a stale
    // detector output never reaches software
    logic flag_view;
    assign flag_view = ctl_link.stable && amp_det_en_o;

    // read word with reserved bit forced to zero
    logic [7:0] rd_word;
    assign rd_word = {flag_view, ext_osc_mode_select, 1'b0,
        ext_osc_drive_select};

    // the crystal qualifier follows the registered crystal enable
    assign ctl_link.xtal_en = amp_det_en_o;

    // control register and decoded drive-circuit outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_osc_mode_select <= `EOC_MODE_OFF;
            ext_osc_drive_select <= `EOC_DRIVE_RESET;
            osc_src_o <= EOC_SRC_NONE;
            osc_div2_o <= 1'b0;
            ext_osc_drive_select_o <= `EOC_DRIVE_RESET;
            amp_det_en_o <= 1'b0;
            osc_pin_input_used_o <= 1'b0;
            osc_pin_output_used_o <= 1'b0;
        end
        else
        begin
            ext_osc_mode_select <= next_mode;
            ext_osc_drive_select <= next_drive;
            osc_src_o <= next_src;
            osc_div2_o <= next_div2;
            ext_osc_drive_select_o <= next_drive;
            amp_det_en_o <= next_xtal;
            osc_pin_input_used_o <= next_xtal;
            osc_pin_output_used_o <= !next_off;
        end
    end

    // read data register; unmapped reads answer zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sfr_rdata_o <= `EOC_REG_RESET;
        else if (sfr_rd_i)
            sfr_rdata_o <= rd_hit ? rd_word : `EOC_RD_ZERO;
    end

    // crystal qualifier
    eoc_xtal_det #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_xtal_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .amp_ok_i(amp_ok_i),
        .ctl(ctl_link.det)
    );

    // writable fields come out of reset cleared with the oscillator off
    a_reset_fields_zero: assert property (@(posedge clk_i)
        $fell(rst_i) |-> ext_osc_mode_select == `EOC_MODE_OFF &&
        ext_osc_drive_select == `EOC_DRIVE_RESET &&
        osc_src_o == EOC_SRC_NONE)
        else $error("fields not cleared by reset");

    // a crystal mode write reaches the decoded source one cycle later
    a_mode_write_decode: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_hit && sfr_wdata_i[`EOC_MODE_MSB:`EOC_MODE_MSB-1] ==
        `EOC_XTAL_PREFIX |=>
        osc_src_o == EOC_SRC_XTAL && amp_det_en_o &&
        osc_div2_o == $past(sfr_wdata_i[`EOC_MODE_LSB]))
        else $error("crystal mode write not decoded");

    // off codes keep source, divide stage and output pin quiet
    a_off_mode_quiet: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ext_osc_mode_select[2:1] == `EOC_OFF_PREFIX |->
        osc_src_o == EOC_SRC_NONE && !osc_div2_o &&
        !osc_pin_output_used_o)
        else $error("off mode drives the circuit");

    // divide-by-2 stage only ever follows a clock or crystal source
    a_div2_source: assert property (@(posedge clk_i)
        disable iff (rst_i)
        osc_div2_o |->
        osc_src_o == EOC_SRC_CLOCK || osc_src_o == EOC_SRC_XTAL)
        else $error("divide stage on for a wrong source");

    // the crystal input pin is only claimed in the crystal modes
    a_pin_input_xtal: assert property (@(posedge clk_i)
        disable iff (rst_i)
        osc_pin_input_used_o |-> osc_src_o == EOC_SRC_XTAL &&
        amp_det_en_o)
        else $error("input pin claimed outside crystal mode");

    // drive code written is forwarded to bias on the next edge
    a_drive_forward: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_hit |=> ext_osc_drive_select_o ==
        $past(sfr_wdata_i[`EOC_DRIVE_MSB:`EOC_DRIVE_LSB]))
        else $error("drive code not forwarded");

    // fields change only on a write that hits this register; a write
    // to a neighbouring address must leave the oscillator alone
    a_fields_hold: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !wr_hit |=> $stable(ext_osc_mode_select) &&
        $stable(ext_osc_drive_select))
        else $error("fields changed without a write");

    // a register read returns the stored mode and drive fields
    a_read_fields: assert property (@(posedge clk_i)
        disable iff (rst_i)
        rd_hit |=>
        sfr_rdata_o[`EOC_MODE_MSB:`EOC_MODE_LSB] ==
        $past(ext_osc_mode_select) &&
        sfr_rdata_o[`EOC_DRIVE_MSB:`EOC_DRIVE_LSB] ==
        $past(ext_osc_drive_select))
        else $error("read word fields wrong");

    // reserved bit always reads zero after a register read
    a_rsvd_reads_zero: assert property (@(posedge clk_i)
        disable iff (rst_i)
        rd_hit |=> !sfr_rdata_o[`EOC_RSVD_BIT])
        else $error("reserved bit read as one");

    // flag never reads one outside crystal mode
    a_flag_needs_xtal: assert property (@(posedge clk_i)
        disable iff (rst_i)
        rd_hit && ext_osc_mode_select[2:1] != `EOC_XTAL_PREFIX |=>
        !sfr_rdata_o[`EOC_FLAG_BIT])
        else $error("stable flag set outside crystal mode");

    // a missing amplitude drops the qualified flag on the next edge
    a_flag_needs_amp: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !amp_ok_i |=> !ctl_link.stable)
        else $error("stable flag set without amplitude");

    // writing a one to the flag bit does not raise it; judged from a
    // mode without crystal drive, where settling cannot end meanwhile
    a_flag_write_ignored: assert property (@(posedge clk_i)
        disable iff (rst_i)
        wr_hit && sfr_wdata_i[`EOC_FLAG_BIT] && !amp_det_en_o |=>
        !flag_view)
        else $error("write reached the stable flag");
endmodule

/* File: rtl/eoc_pkg.sv */
/*
 * types shared by the external oscillator control modules.
 * assumes eoc_defines.svh is on the include path.
 */
package eoc_pkg;
    // kind of source the analog drive circuit is set up for
    typedef enum logic [2:0] {
        EOC_SRC_NONE,
        EOC_SRC_CLOCK,
        EOC_SRC_RC,
        EOC_SRC_CAP,
        EOC_SRC_XTAL
    } eoc_src_t;

    // crystal qualification states
    typedef enum logic [1:0] {
        EOC_DET_OFF,
        EOC_DET_SETTLE,
        EOC_DET_WATCH
    } eoc_det_state_t;
endpackage

/* File: rtl/eoc_xtal_det.sv */
/*
 * crystal qualifier: holds the stable flag low while the amplitude
 * detector settles after the crystal drive is enabled, then follows it.
 * assumes amp_ok_i is already synchronous to clk_i.
 */
`include "eoc_defines.svh"

module eoc_xtal_det #(
    parameter logic [`EOC_CNT_W-1:0] SETTLE_CYCLES =
        `EOC_CNT_W'(`EOC_SETTLE_US * `EOC_CLK_MHZ)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // amplitude detector level
    input wire logic amp_ok_i,
    // control link
    eoc_ctl_if.det ctl
);
    import eoc_pkg::*;

    eoc_det_state_t state;
    eoc_det_state_t next_state;
    logic [`EOC_CNT_W-1:0] cnt;
    logic [`EOC_CNT_W-1:0] next_cnt;
    logic next_stable;
    logic settle_done;

    // settling ends on the last counted cycle
    assign settle_done = (cnt == SETTLE_CYCLES - `EOC_CNT_ONE);
    assign next_stable = (next_state == EOC_DET_WATCH) && amp_ok_i;

    // next state; any drop of the crystal enable restarts settling
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            EOC_DET_OFF:
            begin
                next_cnt = `EOC_CNT_ZERO;
                if (ctl.xtal_en)
                    next_state = EOC_DET_SETTLE;
            end
            EOC_DET_SETTLE:
            begin
                next_cnt = cnt + `EOC_CNT_ONE;
                if (!ctl.xtal_en)
                    next_state = EOC_DET_OFF;
                else if (settle_done)
                    next_state = EOC_DET_WATCH;
            end
            EOC_DET_WATCH:
            begin
                if (!ctl.xtal_en)
                    next_state = EOC_DET_OFF;
            end
            default:
            begin
                next_state = EOC_DET_OFF;
                next_cnt = `EOC_CNT_ZERO;
            end
        endcase
    end

    // state, count and flag registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= EOC_DET_OFF;
            cnt <= `EOC_CNT_ZERO;
            ctl.stable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            ctl.stable <= next_stable;
        end
    end

    // flag is held low for the first cycles after enable
    a_flag_held_low: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $rose(ctl.xtal_en) |-> !ctl.stable [*8])
        else $error("stable flag rose during settling");

    // flag only ever stands after settling ended
    a_flag_after_settle: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ctl.stable |-> $past(state) != EOC_DET_OFF && state == EOC_DET_WATCH)
        else $error("stable flag without completed settling");
endmodule

/* File: verification/eoc_ext_osc_ctrl_tb.sv */
/*
 * self-checking bench for the oscillator control register block.
 * assumes the design files and eoc_defines.svh are compiled first.
 */
`include "eoc_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module eoc_ext_osc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import eoc_pkg::*;
    localparam int SETTLE = 16;
    logic clk_i = 0;
    logic rst_i = 1;
    logic wr = 0;
    logic rd = 0;
    logic lose = 0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] r;
    logic amp_ok, div2, det_en, pin_in, pin_out;
    logic [2:0] drv;
    eoc_src_t src;
    int err_count = 0;
    int n_tests = 0;
    int i;

    // core clock at 25 MHz
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    eoc_ext_osc_ctrl #(.SETTLE_CYCLES(16'(SETTLE))) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .amp_ok_i(amp_ok), .osc_src_o(src), .osc_div2_o(div2),
        .ext_osc_drive_select_o(drv), .amp_det_en_o(det_en),
        .osc_pin_input_used_o(pin_in), .osc_pin_output_used_o(pin_out));

    eoc_xtal_model #(.START_CYCLES(4)) i_xtal (
        .clk_i(clk_i), .rst_i(rst_i), .amp_det_en_i(det_en),
        .lose_i(lose), .amp_ok_o(amp_ok));

    // one-cycle strobes launched on the falling edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk_i);
        wr = 0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr = a;
        rd = 1;
        @(negedge clk_i);
        rd = 0;
        d = rdata;
    endtask

    function automatic eoc_src_t exp_src(input logic [2:0] m);
        case (m)
            3'h2, 3'h3: return EOC_SRC_CLOCK;
            3'h4: return EOC_SRC_RC;
            3'h5: return EOC_SRC_CAP;
            3'h6, 3'h7: return EOC_SRC_XTAL;
            default: return EOC_SRC_NONE;
        endcase
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #400000;
        err_count++;
        $display("[FAIL] %0t run did not finish", $time);
        close_out();
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 0;
        rd_reg(8'hb1, r);
        `CHK(r, 8'h00)
        `CHK(src, EOC_SRC_NONE)
        $display("reset test done");
        // every mode code, with flag and unused bit written as ones
        for (int m = 0; m < 8; m++)
        begin
            wr_reg(8'hb1, {1'b1, 3'(m), 1'b1, 3'(7 - m)});
            `CHK(src, exp_src(3'(m)))
            `CHK(div2, 1'(m == 3 || m == 7))
            `CHK(det_en, 1'(m >= 6))
            `CHK(pin_in, 1'(m >= 6))
            `CHK(pin_out, 1'(m >= 2))
            `CHK(drv, 3'(7 - m))
            rd_reg(8'hb1, r);
            `CHK(r, {1'b0, 3'(m), 1'b0, 3'(7 - m)})
        end
        // foreign address neither written nor read back
        wr_reg(8'hb0, 8'h25);
        `CHK(drv, 3'h0)
        rd_reg(8'hb0, r);
        `CHK(r, 8'h00)
        $display("mode table test done");
        // start-up order: off, crystal with drive 010, then poll
        wr_reg(8'hb1, 8'h00);
        wr_reg(8'hb1, 8'h62);
        for (i = 0; i < 100; i++)
        begin
            rd_reg(8'hb1, r);
            if (r[7])
                break;
        end
        if (i == 100)
        begin
            err_count++;
            $display("[FAIL] %0t stable flag never rose", $time);
            close_out();
        end
        `CHK(1'(i * 2 >= SETTLE), 1'b1)
        `CHK(r, 8'he2)
        // lower drive once running; the flag must stay
        wr_reg(8'hb1, 8'h60);
        rd_reg(8'hb1, r);
        `CHK(r, 8'he0)
        // amplitude loss: flag follows the detector
        @(negedge clk_i);
        lose = 1;
        @(negedge clk_i);
        rd_reg(8'hb1, r);
        `CHK(r[7], 1'b0)
        lose = 0;
        repeat (3) @(negedge clk_i);
        // leaving crystal mode masks the flag, re-entry restarts settling
        wr_reg(8'hb1, 8'h30);
        rd_reg(8'hb1, r);
        `CHK(r, 8'h30)
        wr_reg(8'hb1, 8'h60);
        rd_reg(8'hb1, r);
        `CHK(r, 8'h60)
        $display("crystal start test done");
        // reset in mid-run clears the register
        @(negedge clk_i);
        rst_i = 1;
        @(negedge clk_i);
        rst_i = 0;
        rd_reg(8'hb1, r);
        `CHK(r, 8'h00)
        `CHK(det_en, 1'b0)
        $display("second reset test done");
        close_out();
    end
endmodule

/* File: verification/eoc_xtal_model.sv */
/*
 * partner model: crystal plus amplitude detector at the oscillator pins.
 * assumes the drive enable comes from the block on the same core clock.
 */
module eoc_xtal_model #(
    parameter int START_CYCLES = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // drive enable and injected fault
    input wire logic amp_det_en_i,
    input wire logic lose_i,
    // detector level
    output logic amp_ok_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;

    // swing builds up only while driven, so a disabled drive restarts it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !amp_det_en_i)
            cnt <= 0;
        else if (cnt < START_CYCLES)
            cnt <= cnt + 1;
    end

    // a lost crystal drops the level at once
    assign amp_ok_o = amp_det_en_i && !lose_i && (cnt >= START_CYCLES);
endmodule
